// File: hw/psw_pkg.sv
package psw_pkg;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int QSEC_MS = 250;
  localparam int QSEC_CYC = SYS_CLK_HZ / 1000 * QSEC_MS;
  localparam int SHELF_OSC_HZ = 2000;
  localparam int SHELF_TICK_CYC = SYS_CLK_HZ / SHELF_OSC_HZ;
  localparam int SLOW_OSC_HZ = 262144;
  localparam int SLOW_PER_CYC = SYS_CLK_HZ / SLOW_OSC_HZ;
  localparam logic [7:0] OSC_MIN_CYC = 8'(SLOW_PER_CYC / 2);
  localparam logic [7:0] OSC_MAX_CYC = 8'(SLOW_PER_CYC * 2);
  localparam int SD_HOLD_S = 5;
  localparam logic [4:0] SD_QUARTERS = 5'(SD_HOLD_S * 1000 / QSEC_MS);
  localparam int RECYCLE_OFF_US = 100;
  localparam logic [11:0] RECYCLE_OFF_CYC =
    12'((SYS_CLK_HZ / 1000000 * RECYCLE_OFF_US + 0));
  localparam int DEBOUNCE_SLOW = 8;
  localparam logic [12:0] SHELF_SEC [8] =
    '{13'h0021, 13'h0042, 13'h0083, 13'h0106,
      13'h020C, 13'h0418, 13'h0831, 13'h1062};
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WD_ALERT = 4'h1;
  localparam logic [3:0] REG_WD_RESET = 4'h2;
  localparam logic [3:0] REG_WD_FETOFF = 4'h3;
  localparam logic [3:0] REG_SHELF = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_CMD = 4'h6;
  localparam int CTRL_ACT_LSB = 0;
  localparam int CTRL_OSC_FET = 2;
  localparam int CTRL_FET_REQ = 3;
  localparam int CMD_RECYCLE = 0;
  localparam int CMD_ACK = 1;
  localparam int CMD_SHELF = 2;
  localparam int ST_FETS = 0;
  localparam int ST_WD_ALERT = 1;
  localparam int ST_MCU_RST = 2;
  localparam int ST_REG_ON = 3;
  localparam int ST_SHUTDOWN = 4;
  localparam int ST_SHELF = 5;
  localparam int ST_WOKE = 6;
  localparam int ST_OSC_FAULT = 7;
  localparam int ST_BUS_ALERT = 8;
  localparam int ST_STAGE_LSB = 9;
  localparam logic [1:0] ACT_ALERT = 2'h0;
  localparam logic [1:0] ACT_HOLD = 2'h1;
  localparam logic [1:0] ACT_REGOFF = 2'h2;
  typedef enum logic [1:0] {WD_ST_ALERT, WD_ST_RESET, WD_ST_FETOFF}
    psw_wd_type;
endpackage

// File: hw/psw_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface psw_tick_if;
  logic qsec;
  logic shelf;
  modport src(output qsec, output shelf);
  modport dst(input qsec, input shelf);
endinterface
`default_nettype wire

// File: hw/psw_timebase.sv
`timescale 1ns/100ps
`default_nettype none
module psw_timebase #(
  parameter int QSEC_CYCLES = psw_pkg::QSEC_CYC,
  parameter int SHELF_CYCLES = psw_pkg::SHELF_TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  psw_tick_if.src tick
);
  import psw_pkg::*;
  localparam int QW = $clog2(QSEC_CYCLES + 1);
  localparam int SW = $clog2(SHELF_CYCLES + 1);
  localparam logic [QW-1:0] Q_LAST = QW'(QSEC_CYCLES - 1);
  localparam logic [SW-1:0] S_LAST = SW'(SHELF_CYCLES - 1);
  typedef struct packed {
    logic [QW-1:0] qcnt;
    logic [SW-1:0] scnt;
    logic qsec;
    logic shelf;
  } psw_tb_type;
  psw_tb_type tb_reg;
  psw_tb_type tb_next;
  // Free running, so quarter-second phase is arbitrary to any event
  always_comb
  begin
    tb_next = tb_reg;
    tb_next.qsec = (tb_reg.qcnt == Q_LAST);
    tb_next.qcnt = tb_next.qsec ? '0 : tb_reg.qcnt + 1'b1;
    tb_next.shelf = (tb_reg.scnt == S_LAST);
    tb_next.scnt = tb_next.shelf ? '0 : tb_reg.scnt + 1'b1;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      tb_reg <= '0;
    else
      tb_reg <= tb_next;
  end
  assign tick.qsec = tb_reg.qsec;
  assign tick.shelf = tb_reg.shelf;
endmodule // psw_timebase
`default_nettype wire

// File: hw/psw_supervisor.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module psw_supervisor #(
  parameter int QSEC_CYCLES = psw_pkg::QSEC_CYC,
  parameter int SHELF_TICK_CYCLES = psw_pkg::SHELF_TICK_CYC,
  parameter int DEBOUNCE = psw_pkg::DEBOUNCE_SLOW
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic reset_shutdown_pin_i,
  input wire logic slow_osc_i,
  output logic core_supply_regulator_en_o,
  output logic mcu_reset_o,
  output logic mcu_alert_o,
  output logic fets_on_o,
  output logic shutdown_o,
  output logic shelf_wake_o,
  output logic slow_osc_fault_o
);
  import psw_pkg::*;
  localparam logic [7:0] DB_LAST = 8'(DEBOUNCE - 1);
  typedef struct packed {
    logic [15:0] rdata;
    logic [1:0] action;
    logic osc_fet_en;
    logic fet_req;
    logic [6:0] alert_set;
    logic [4:0] reset_set;
    logic [4:0] off_set;
    logic [2:0] shelf_code;
    logic fets_on;
    logic wd_permit;
    psw_wd_type wd;
    logic [6:0] wd_cnt;
    logic wd_alert;
    logic wd_reset;
    logic osc_q;
    logic [7:0] db_cnt;
    logic pin_db;
    logic [4:0] sd_cnt;
    logic shutdown;
    logic bus_alert;
    logic pin_rst;
    logic pin_reg_off;
    logic [11:0] rc_cnt;
    logic recycling;
    logic [7:0] osc_cnt;
    logic osc_fault;
    logic osc_armed;
    logic shelf_mode;
    logic [23:0] shelf_cnt;
    logic woke;
    logic shelf_wake;
    logic mcu_reset_q;
    logic reg_on_q;
    logic alert_q;
  } psw_state_type;
  psw_state_type s_reg;
  psw_state_type s_next;
  psw_tick_if tick();
  psw_timebase #(
    .QSEC_CYCLES(QSEC_CYCLES),
    .SHELF_CYCLES(SHELF_TICK_CYCLES)
  ) u_timebase (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick(tick.src)
  );
  logic wr_cmd;
  logic ack;
  logic recycle_cmd;
  logic shelf_cmd;
  logic osc_edge;
  assign wr_cmd = wr_i && (addr_i == REG_CMD);
  assign ack = wr_cmd && wdata_i[CMD_ACK];
  assign recycle_cmd = wr_cmd && wdata_i[CMD_RECYCLE];
  assign shelf_cmd = wr_cmd && wdata_i[CMD_SHELF];
  assign osc_edge = slow_osc_i && !s_reg.osc_q;
  function automatic logic [23:0] shelf_load(input logic [2:0] code);
    shelf_load = 24'(SHELF_SEC[code]) * 24'(SHELF_OSC_HZ) - 24'h000001;
  endfunction
  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = '0;
    s_next.shelf_wake = 1'b0;
    s_next.osc_q = slow_osc_i;
    // Bus writes first, so hardware sets below win over clears
    if (wr_i)
    begin
      if (addr_i == REG_CTRL)
      begin
        s_next.action = wdata_i[CTRL_ACT_LSB +: 2];
        s_next.osc_fet_en = wdata_i[CTRL_OSC_FET];
        s_next.fet_req = wdata_i[CTRL_FET_REQ];
      end
      else if (addr_i == REG_WD_ALERT)
        s_next.alert_set = wdata_i[6:0];
      else if (addr_i == REG_WD_RESET)
        s_next.reset_set = wdata_i[4:0];
      else if (addr_i == REG_WD_FETOFF)
        s_next.off_set = wdata_i[4:0];
      else if (addr_i == REG_SHELF)
        s_next.shelf_code = wdata_i[2:0];
      else if (addr_i == REG_STATUS)
      begin
        if (wdata_i[ST_WOKE])
          s_next.woke = 1'b0;
        if (wdata_i[ST_OSC_FAULT])
          s_next.osc_fault = 1'b0;
        if (wdata_i[ST_BUS_ALERT])
          s_next.bus_alert = 1'b0;
      end
    end
    // Pin debounce in slow oscillator edges; release acts at once
    if (!reset_shutdown_pin_i)
    begin
      s_next.db_cnt = '0;
      s_next.pin_db = 1'b0;
      s_next.sd_cnt = '0;
    end
    else if (!s_reg.pin_db && osc_edge)
    begin
      if (s_reg.db_cnt == DB_LAST)
        s_next.pin_db = 1'b1;
      else
        s_next.db_cnt = s_reg.db_cnt + 8'h01;
    end
    if (s_next.pin_db && !s_reg.pin_db && s_reg.action == ACT_ALERT)
      s_next.bus_alert = 1'b1;
    s_next.pin_rst = s_next.pin_db &&
      (s_reg.action == ACT_HOLD || s_reg.action == ACT_REGOFF);
    s_next.pin_reg_off = s_next.pin_db && s_reg.action == ACT_REGOFF;
    // Quarter ticks are free running: one extra tick keeps it >= 5 s
    if (s_reg.pin_db && reset_shutdown_pin_i && tick.qsec)
    begin
      if (s_reg.sd_cnt == SD_QUARTERS)
      begin
        if (!s_reg.shutdown)
          s_next.shelf_cnt = shelf_load(s_reg.shelf_code);
        s_next.shutdown = 1'b1;
      end
      else
        s_next.sd_cnt = s_reg.sd_cnt + 5'h01;
    end
    // Core supply recycle
    if (s_reg.recycling)
    begin
      if (s_reg.rc_cnt == RECYCLE_OFF_CYC - 12'h001)
        s_next.recycling = 1'b0;
      else
        s_next.rc_cnt = s_reg.rc_cnt + 12'h001;
    end
    else if (recycle_cmd)
    begin
      s_next.recycling = 1'b1;
      s_next.rc_cnt = '0;
    end
    // Slow oscillator monitor: too short or too long a period
    if (osc_edge)
    begin
      // First edge after reset closes only a partial period
      if (s_reg.osc_armed && s_reg.osc_cnt < OSC_MIN_CYC)
        s_next.osc_fault = 1'b1;
      s_next.osc_cnt = '0;
      s_next.osc_armed = 1'b1;
    end
    else if (s_reg.osc_cnt < OSC_MAX_CYC)
      s_next.osc_cnt = s_reg.osc_cnt + 8'h01;
    else
      s_next.osc_fault = 1'b1;
    // FET control; pin shutdown and an enabled oscillator fault also force it off below
    if (!s_reg.fet_req)
      s_next.fets_on = 1'b0;
    else if (s_reg.wd_permit)
      s_next.fets_on = 1'b1;
    // Watchdog; ack restarts all stages even against a same-cycle expiry
    if (!s_reg.fets_on)
    begin
      s_next.wd = WD_ST_ALERT;
      s_next.wd_cnt = '0;
      s_next.wd_alert = 1'b0;
      s_next.wd_reset = 1'b0;
    end
    else if (!ack && tick.qsec)
    begin
      case (s_reg.wd)
        WD_ST_ALERT:
          if (s_reg.wd_cnt == s_reg.alert_set)
          begin
            s_next.wd = WD_ST_RESET;
            s_next.wd_cnt = '0;
            s_next.wd_alert = 1'b1;
          end
          else
            s_next.wd_cnt = s_reg.wd_cnt + 7'h01;
        WD_ST_RESET:
          if (s_reg.wd_cnt == {2'h0, s_reg.reset_set})
          begin
            s_next.wd = WD_ST_FETOFF;
            s_next.wd_cnt = '0;
            s_next.wd_reset = 1'b1;
          end
          else
            s_next.wd_cnt = s_reg.wd_cnt + 7'h01;
        default:
          if (s_reg.wd_cnt == {2'h0, s_reg.off_set})
          begin
            s_next.wd = WD_ST_ALERT;
            s_next.wd_cnt = '0;
            s_next.fets_on = 1'b0;
            s_next.wd_permit = 1'b0;
          end
          else
            s_next.wd_cnt = s_reg.wd_cnt + 7'h01;
      endcase
    end
    if (ack)
    begin
      s_next.wd = WD_ST_ALERT;
      s_next.wd_cnt = '0;
      s_next.wd_alert = 1'b0;
      s_next.wd_reset = 1'b0;
      s_next.wd_permit = 1'b1;
    end
    if (s_next.osc_fault && s_reg.osc_fet_en)
      s_next.fets_on = 1'b0;
    if (s_next.shutdown)
      s_next.fets_on = 1'b0;
    // Shelf countdown, also the periodic wake in shutdown
    if (shelf_cmd && !s_reg.shutdown)
    begin
      s_next.shelf_mode = 1'b1;
      s_next.shelf_cnt = shelf_load(s_reg.shelf_code);
    end
    else if ((s_reg.shelf_mode || s_reg.shutdown) && tick.shelf)
    begin
      if (s_reg.shelf_cnt == '0)
      begin
        s_next.shelf_wake = 1'b1;
        if (s_reg.shutdown)
          s_next.shelf_cnt = shelf_load(s_reg.shelf_code);
        else
        begin
          s_next.shelf_mode = 1'b0;
          s_next.woke = 1'b1;
        end
      end
      else
        s_next.shelf_cnt = s_reg.shelf_cnt - 24'h000001;
    end
    s_next.mcu_reset_q = s_next.wd_reset || s_next.pin_rst ||
      s_next.recycling;
    s_next.reg_on_q = !(s_next.recycling || s_next.pin_reg_off ||
      s_next.shutdown);
    s_next.alert_q = (s_next.wd_alert && s_next.fets_on) ||
      s_next.bus_alert;
    // Register reads, answered in the next cycle
    if (rd_i)
    begin
      if (addr_i == REG_CTRL)
        s_next.rdata = {12'h000, s_reg.fet_req, s_reg.osc_fet_en,
          s_reg.action};
      else if (addr_i == REG_WD_ALERT)
        s_next.rdata = {9'h000, s_reg.alert_set};
      else if (addr_i == REG_WD_RESET)
        s_next.rdata = {11'h000, s_reg.reset_set};
      else if (addr_i == REG_WD_FETOFF)
        s_next.rdata = {11'h000, s_reg.off_set};
      else if (addr_i == REG_SHELF)
        s_next.rdata = {13'h0000, s_reg.shelf_code};
      else if (addr_i == REG_STATUS)
        s_next.rdata = {5'h00, s_reg.wd, s_reg.bus_alert, s_reg.osc_fault,
          s_reg.woke, s_reg.shelf_mode, s_reg.shutdown, s_reg.reg_on_q,
          s_reg.mcu_reset_q, s_reg.wd_alert, s_reg.fets_on};
      else
        s_next.rdata = '0;
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      s_reg <= '0;
      s_reg.reg_on_q <= 1'b1;
    end
    else
      s_reg <= s_next;
  end
  assign rdata_o = s_reg.rdata;
  assign core_supply_regulator_en_o = s_reg.reg_on_q;
  assign mcu_reset_o = s_reg.mcu_reset_q;
  assign mcu_alert_o = s_reg.alert_q;
  assign fets_on_o = s_reg.fets_on;
  assign shutdown_o = s_reg.shutdown;
  assign shelf_wake_o = s_reg.shelf_wake;
  assign slow_osc_fault_o = s_reg.osc_fault;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence seq_stage1_end;
    s_reg.fets_on && !ack && tick.qsec && s_reg.wd == WD_ST_ALERT &&
      s_reg.wd_cnt == s_reg.alert_set;
  endsequence
  sequence seq_alert_raised;
    s_reg.wd_alert && s_reg.wd == WD_ST_RESET && s_reg.wd_cnt == 7'h00;
  endsequence
  sequence seq_recycle_start;
    recycle_cmd && !s_reg.recycling;
  endsequence
  AST_RECYCLE_OFF: assert property (seq_recycle_start |=>
    !core_supply_regulator_en_o && mcu_reset_o)
    else $error("recycle did not drop core supply");
  AST_RECYCLE_ON: assert property ($fell(s_reg.recycling) &&
    !s_reg.pin_reg_off && !s_reg.shutdown |-> core_supply_regulator_en_o)
    else $error("core supply not restored after recycle");
  AST_PIN_ALERT: assert property ($rose(s_reg.pin_db) &&
    $past(s_reg.action) == ACT_ALERT |-> mcu_alert_o)
    else $error("pin alert action missing");
  AST_PIN_HOLD: assert property (s_reg.pin_db &&
    $past(s_reg.action) == ACT_HOLD |-> mcu_reset_o)
    else $error("mcu not held in reset while pin high");
  AST_PIN_REGOFF: assert property (s_reg.pin_db &&
    $past(s_reg.action) == ACT_REGOFF |->
    mcu_reset_o && !core_supply_regulator_en_o)
    else $error("supply action not applied");
  AST_FET_CAUSE: assert property ($fell(fets_on_o) |->
    !$past(s_reg.fet_req) || $past(s_reg.wd) == WD_ST_FETOFF ||
    s_reg.shutdown || s_reg.osc_fault)
    else $error("FETs dropped without a cause");
  AST_SHUTDOWN: assert property (s_reg.pin_db && reset_shutdown_pin_i &&
    tick.qsec && s_reg.sd_cnt == SD_QUARTERS |=> shutdown_o && !fets_on_o)
    else $error("shutdown not entered after hold");
  AST_WD_IDLE: assert property (!fets_on_o && !$past(fets_on_o) |->
    s_reg.wd_cnt == 7'h00 && !s_reg.wd_alert)
    else $error("watchdog ran with FETs off");
  AST_STAGE1: assert property (seq_stage1_end |=> seq_alert_raised)
    else $error("stage one expiry did not raise alert");
  AST_ACK: assert property (ack |=> s_reg.wd_cnt == 7'h00 &&
    !s_reg.wd_alert && !s_reg.wd_reset && s_reg.wd_permit)
    else $error("acknowledge did not clear watchdog");
  AST_ALERT_GATE: assert property (mcu_alert_o && !s_reg.bus_alert |->
    fets_on_o)
    else $error("watchdog alert with FETs off");
  AST_OSC_FET: assert property (s_reg.osc_fault &&
    $past(s_reg.osc_fet_en) |-> !fets_on_o)
    else $error("oscillator fault left FETs on");
  AST_SHELF_LOAD: assert property (shelf_cmd && !s_reg.shutdown |=>
    s_reg.shelf_mode && s_reg.shelf_cnt == shelf_load($past(s_reg.shelf_code)))
    else $error("shelf delay not loaded");
  AST_SHELF_WAKE: assert property (s_reg.shelf_mode && !s_reg.shutdown &&
    tick.shelf && s_reg.shelf_cnt == '0 && !shelf_cmd |=>
    shelf_wake_o && s_reg.woke && !s_reg.shelf_mode)
    else $error("shelf expiry did not wake");
endmodule // psw_supervisor
`default_nettype wire

// File: test/psw_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module psw_far_end #(
  parameter int OSC_HALF = 40
) (
  input wire logic sys_clk_i,
  input wire logic press_i,
  input wire logic osc_run_i,
  output logic pin_o,
  output logic slow_osc_o
);
  int half_cnt = 0;
  logic osc_q = 1'b0;
  // Driver keeps the pin low unless a press is commanded
  assign pin_o = press_i;
  assign slow_osc_o = osc_q;
  // A stopped source freezes, as a dead oscillator would
  always @(posedge sys_clk_i)
  begin
    if (!osc_run_i)
    begin
      half_cnt <= 0;
    end
    else if (half_cnt == OSC_HALF - 1)
    begin
      half_cnt <= 0;
      osc_q <= !osc_q;
    end
    else
    begin
      half_cnt <= half_cnt + 1;
    end
  end
endmodule // psw_far_end
`default_nettype wire

// File: test/pack_supervisor_reset_watchdog_test.sv
`timescale 1ns/100ps
`default_nettype none
module pack_supervisor_reset_watchdog_test;
  import psw_pkg::*;
  localparam int QS = 20;
  localparam int LIMIT = 90000;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic press = 1'b0;
  logic osc_run = 1'b1;
  logic [15:0] rdata_o;
  logic [15:0] rd_val;
  logic [6:0] held;
  logic [6:0] rel;
  wire pin;
  wire slow_osc;
  // Bits: 0 alert, 1 mcu reset, 2 fets, 3 supply, 4 wake, 5 fault, 6 off
  wire [6:0] outs;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;

  psw_far_end far (
    .sys_clk_i(sys_clk_i),
    .press_i(press),
    .osc_run_i(osc_run),
    .pin_o(pin),
    .slow_osc_o(slow_osc)
  );

  // Shelf tick of one cycle keeps the 33 s preset inside the run
  psw_supervisor #(
    .QSEC_CYCLES(QS),
    .SHELF_TICK_CYCLES(1),
    .DEBOUNCE(8)
  ) DUT (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .reset_shutdown_pin_i(pin),
    .slow_osc_i(slow_osc),
    .core_supply_regulator_en_o(outs[3]),
    .mcu_reset_o(outs[1]),
    .mcu_alert_o(outs[0]),
    .fets_on_o(outs[2]),
    .shutdown_o(outs[6]),
    .shelf_wake_o(outs[4]),
    .slow_osc_fault_o(outs[5])
  );

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic test_done;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic win(input int lo, input int hi);
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    rd_val = rdata_o;
    chk(rd_val, e);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  // Bounded wait; n holds the cycles spent
  task automatic wait_out(input int b, input logic v, input int lim);
    #1;
    n = 0;
    while (outs[b] !== v && n < lim)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic press_for(input int hold);
    wr(REG_CMD, 16'h0002);
    press <= 1'b1;
    cycles(hold);
    held = outs;
    @(posedge sys_clk_i);
    press <= 1'b0;
    cycles(6);
    rel = outs;
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    cycles(1);
    chk(16'(outs), 16'h0008);
    rchk(REG_STATUS, 16'h0008);
    rchk(4'hF, 16'h0000);
    $display("test reset done");

    wr(REG_CMD, 16'h0001);
    #1;
    chk(16'(outs), 16'h0002);
    wait_out(3, 1'b1, 2100);
    win(1990, 2010);
    cycles(3);
    chk(16'(outs), 16'h0008);
    $display("test recycle done");

    wr(REG_SHELF, 16'h0000);
    wr(REG_CMD, 16'h0004);
    rchk(REG_STATUS, 16'h0028);
    wait_out(4, 1'b1, 66100);
    win(65980, 66010);
    rchk(REG_STATUS, 16'h0048);
    wr(REG_STATUS, 16'h0040);
    rchk(REG_STATUS, 16'h0008);
    for (int c = 0; c < 8; c++)
    begin
      wr(REG_SHELF, 16'(c));
      rchk(REG_SHELF, 16'(c));
    end
    $display("test shelf done");

    wr(REG_WD_ALERT, 16'h0001);
    wr(REG_WD_RESET, 16'h0003);
    wr(REG_WD_FETOFF, 16'h0000);
    wr(REG_CTRL, 16'h0008);
    cycles(60);
    chk(16'(outs), 16'h0008);
    wr(REG_CMD, 16'h0002);
    wait_out(2, 1'b1, 5);
    chk(16'(outs[2]), 16'h0001);
    repeat (6)
    begin
      cycles(15);
      wr(REG_CMD, 16'h0002);
    end
    chk(16'(outs[0]), 16'h0000);
    wait_out(0, 1'b1, 60);
    win(21, 43);
    chk(16'(outs[2]), 16'h0001);
    wait_out(1, 1'b1, 100);
    win(75, 85);
    wait_out(2, 1'b0, 40);
    win(15, 25);
    cycles(2);
    chk(16'(outs[0]), 16'h0000);
    wr(REG_WD_ALERT, 16'h007F);
    wr(REG_CMD, 16'h0002);
    cycles(3);
    chk(16'(outs), 16'h000C);
    $display("test watchdog done");

    wr(REG_CTRL, 16'h0009);
    press_for(300);
    chk(16'(held[1]), 16'h0000);
    press_for(900);
    chk(16'(held & 7'h06), 16'h0006);
    chk(16'(rel[1]), 16'h0000);
    wr(REG_CTRL, 16'h000A);
    press_for(900);
    chk(16'(held & 7'h0E), 16'h0006);
    chk(16'(rel & 7'h0A), 16'h0008);
    wr(REG_CTRL, 16'h0008);
    press_for(900);
    chk(16'(held[0]), 16'h0001);
    chk(16'(rel[0]), 16'h0001);
    rchk(REG_STATUS, 16'h0109);
    wr(REG_STATUS, 16'h0100);
    cycles(3);
    chk(16'(outs[0]), 16'h0000);
    $display("test pin done");

    wr(REG_CTRL, 16'h000C);
    wr(REG_CMD, 16'h0002);
    osc_run <= 1'b0;
    cycles(200);
    chk(16'(outs & 7'h24), 16'h0020);
    @(posedge sys_clk_i);
    osc_run <= 1'b1;
    cycles(300);
    wr(REG_STATUS, 16'h0080);
    cycles(3);
    chk(16'(outs[5]), 16'h0000);
    $display("test oscillator done");

    wr(REG_CTRL, 16'h000B);
    wr(REG_CMD, 16'h0002);
    cycles(3);
    chk(16'(outs[2]), 16'h0001);
    @(posedge sys_clk_i);
    press <= 1'b1;
    cycles(950);
    chk(16'(outs[6]), 16'h0000);
    wait_out(6, 1'b1, 150);
    chk(16'(outs & 7'h4C), 16'h0040);
    @(posedge sys_clk_i);
    press <= 1'b0;
    $display("test shutdown done");
    test_done();
  end
endmodule // pack_supervisor_reset_watchdog_test
`default_nettype wire
